/* lvr_pkg.sv */
// Constants for the low-voltage detector interrupt and reset controller
package lvr_pkg;

    typedef enum logic [1:0] {LVR_OFF, LVR_INT, LVR_COMBO, LVR_RST} lvr_mode_t;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_LEVEL  = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_MASK   = 8'h0C;

    // Field positions
    localparam int BIT_WE       = 7;
    localparam int BIT_MODESEL  = 7;
    localparam int BIT_LEVELSEL = 0;
    localparam int ST_WARN      = 0;
    localparam int ST_DETRST    = 1;
    localparam int ST_SETTLED   = 2;
    localparam int ST_W         = 3;

    // Reset values of the sense level register per mode, and of the mask
    localparam logic [7:0] LEVEL_COMBO = 8'h00;
    localparam logic [7:0] LEVEL_RST   = 8'h81;
    localparam logic [7:0] LEVEL_INT   = 8'h01;
    localparam logic [2:0] MASK_RESET  = 3'h7;

    // Timing
    localparam int CLK_PERIOD_NS  = 50;
    localparam int DET_DELAY_NS   = 300000;
    localparam int DET_DELAY_CYC  = DET_DELAY_NS / CLK_PERIOD_NS;
    localparam int PIPE_CYC       = 4;
    localparam int SETTLE_NS      = 400000;
    localparam int SETTLE_CYC     = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] SETTLE_OSC = 3'h5;

endpackage

/* lvr_ctrl.sv */
// Low-voltage detector control in off, interrupt, reset and combined interrupt and reset modes
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module lvr_ctrl #(
    parameter int FILT_CYC   = lvr_pkg::DET_DELAY_CYC - lvr_pkg::PIPE_CYC,
    parameter int SETTLE_MAX = lvr_pkg::SETTLE_CYC
) (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    // Option byte mode field
    input  wire logic        det_mode_opt_hi,
    input  wire logic        det_mode_opt_lo,
    // Analog comparators, asynchronous, high while supply is above threshold
    input  wire logic        above_high_threshold,
    input  wire logic        above_low_threshold,
    // Low-speed oscillator, sampled as data
    input  wire logic        slow_osc_clock,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // System side
    output logic             detector_reset,
    output logic             low_supply_irq,
    output logic             irq
);

    typedef enum logic [1:0] {S_POWERUP, S_RUN, S_WARNED, S_LVRESET} lvr_state_t;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == lvr_pkg::OFS_CTRL) || (a == lvr_pkg::OFS_LEVEL)
              || (a == lvr_pkg::OFS_STATUS) || (a == lvr_pkg::OFS_MASK);
    endfunction

    function automatic lvr_pkg::lvr_mode_t decode_mode(input logic hi, input logic lo);
        unique case ({hi, lo})
            2'b10:   decode_mode = lvr_pkg::LVR_COMBO;
            2'b11:   decode_mode = lvr_pkg::LVR_RST;
            2'b01:   decode_mode = lvr_pkg::LVR_INT;
            default: decode_mode = lvr_pkg::LVR_OFF;
        endcase
    endfunction

    lvr_pkg::lvr_mode_t      mode;
    lvr_state_t              state;
    lvr_state_t              next_state;
    logic [1:0]              cmp_raw;
    logic [1:0]              sync1;
    logic [1:0]              sync2;
    logic [1:0]              filt;
    logic                    level_write_enable;
    logic [7:0]              sense_level_reg;
    logic [lvr_pkg::ST_W-1:0] status;
    logic [lvr_pkg::ST_W-1:0] mask;
    logic [2:0]              osc_sync;
    logic [2:0]              osc_cnt;
    logic [13:0]             settle_cnt;
    logic                    settled;
    logic                    suppress;
    logic                    warn_evt;
    logic                    rst_evt;
    logic                    wr;
    logic                    rd;

    assign mode     = decode_mode(det_mode_opt_hi, det_mode_opt_lo);
    assign cmp_raw  = {above_low_threshold, above_high_threshold};
    assign suppress = level_write_enable;
    assign pready   = clk_en;
    assign wr       = psel && penable && pwrite && clk_en;
    assign rd       = psel && penable && !pwrite && clk_en;

    // Two flops per comparator, then a stability filter
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_cmp
            logic [13:0] cnt;
            always_ff @(posedge clk)
            begin
                if (reset)
                begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                end
                else if (clk_en)
                begin
                    sync1[gi] <= cmp_raw[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
            // Filter rejects chatter yet stays inside the detection delay bound
            always_ff @(posedge clk)
            begin
                if (reset)
                begin
                    cnt      <= 14'h0000;
                    filt[gi] <= 1'b0;
                end
                else if (clk_en)
                begin
                    if (sync2[gi] == filt[gi])
                        cnt <= 14'h0000;
                    else if (cnt >= 14'(FILT_CYC - 1))
                    begin
                        cnt      <= 14'h0000;
                        filt[gi] <= sync2[gi];
                    end
                    else
                        cnt <= cnt + 14'h0001;
                end
            end
        end
    endgenerate

    // Detector sequence
    always_comb
    begin
        next_state = state;
        warn_evt   = 1'b0;
        rst_evt    = 1'b0;
        unique case (state)
            S_POWERUP:
                if (filt[0])
                    next_state = S_RUN;
            S_RUN:
                if (!suppress)
                begin
                    if (mode == lvr_pkg::LVR_RST && !filt[0])
                    begin
                        next_state = S_LVRESET;
                        rst_evt    = 1'b1;
                    end
                    else if (mode != lvr_pkg::LVR_RST && mode != lvr_pkg::LVR_OFF
                             && !filt[0])
                    begin
                        next_state = S_WARNED;
                        warn_evt   = 1'b1;
                    end
                end
            S_WARNED:
                if (filt[0])
                    next_state = S_RUN;
                else if (!suppress && mode == lvr_pkg::LVR_COMBO && !filt[1])
                begin
                    next_state = S_LVRESET;
                    rst_evt    = 1'b1;
                end
            S_LVRESET:
                if (filt[0])
                    next_state = S_RUN;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            state <= S_POWERUP;
        else if (clk_en)
            state <= next_state;
    end

    // Reset is driven from state, so release follows the filtered comparator
    always_ff @(posedge clk)
    begin
        if (reset)
            detector_reset <= 1'b1;
        else if (clk_en)
            detector_reset <= (mode != lvr_pkg::LVR_OFF)
                           && (next_state == S_POWERUP || next_state == S_LVRESET);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            low_supply_irq <= 1'b0;
        else if (clk_en)
            low_supply_irq <= warn_evt && !mask[lvr_pkg::ST_WARN];
    end

    // Control and sense level registers
    always_ff @(posedge clk)
    begin
        if (reset)
            level_write_enable <= 1'b0;
        else if (clk_en && wr && paddr == lvr_pkg::OFS_CTRL)
            level_write_enable <= pwdata[lvr_pkg::BIT_WE];
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            unique case (mode)
                lvr_pkg::LVR_RST: sense_level_reg <= lvr_pkg::LEVEL_RST;
                lvr_pkg::LVR_INT: sense_level_reg <= lvr_pkg::LEVEL_INT;
                default:          sense_level_reg <= lvr_pkg::LEVEL_COMBO;
            endcase
        end
        else if (clk_en && wr && paddr == lvr_pkg::OFS_LEVEL && level_write_enable)
        begin
            sense_level_reg[lvr_pkg::BIT_MODESEL]  <= pwdata[lvr_pkg::BIT_MODESEL];
            sense_level_reg[lvr_pkg::BIT_LEVELSEL] <= pwdata[lvr_pkg::BIT_LEVELSEL];
        end
    end

    // Settling aid: counts slow clock edges and time while write enable is set
    always_ff @(posedge clk)
    begin
        if (reset)
            osc_sync <= 3'h0;
        else if (clk_en)
            osc_sync <= {osc_sync[1:0], slow_osc_clock};
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            osc_cnt    <= 3'h0;
            settle_cnt <= 14'h0000;
        end
        else if (clk_en)
        begin
            if (!level_write_enable)
            begin
                osc_cnt    <= 3'h0;
                settle_cnt <= 14'h0000;
            end
            else
            begin
                if (osc_sync[1] && !osc_sync[2] && osc_cnt != lvr_pkg::SETTLE_OSC)
                    osc_cnt <= osc_cnt + 3'h1;
                if (settle_cnt != 14'(SETTLE_MAX))
                    settle_cnt <= settle_cnt + 14'h0001;
            end
        end
    end

    assign settled = level_write_enable
                  && (osc_cnt == lvr_pkg::SETTLE_OSC || settle_cnt == 14'(SETTLE_MAX));

    // Sticky status, cleared by read; a new event wins over the clear
    always_ff @(posedge clk)
    begin
        if (reset)
            status <= '0;
        else if (clk_en)
        begin
            if (rd && paddr == lvr_pkg::OFS_STATUS)
                status <= '0;
            if (warn_evt)
                status[lvr_pkg::ST_WARN] <= 1'b1;
            if (rst_evt)
                status[lvr_pkg::ST_DETRST] <= 1'b1;
            if (settled)
                status[lvr_pkg::ST_SETTLED] <= 1'b1;
        end
    end

    // Mask returns to all set after any reset, the detector's own included
    always_ff @(posedge clk)
    begin
        if (reset)
            mask <= lvr_pkg::MASK_RESET;
        else if (clk_en)
        begin
            if (rst_evt)
                mask <= lvr_pkg::MASK_RESET;
            else if (wr && paddr == lvr_pkg::OFS_MASK)
                mask <= pwdata[lvr_pkg::ST_W-1:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            irq <= 1'b0;
        else if (clk_en)
            irq <= |(status & ~mask) && !suppress;
    end

    // APB read data captured in the setup cycle
    always_ff @(posedge clk)
    begin
        if (reset)
            prdata <= 32'h0000_0000;
        else if (clk_en && psel && !penable)
        begin
            prdata <= 32'h0000_0000;
            unique case (paddr)
                lvr_pkg::OFS_CTRL:   prdata[lvr_pkg::BIT_WE] <= level_write_enable;
                lvr_pkg::OFS_LEVEL:  prdata[7:0] <= sense_level_reg;
                lvr_pkg::OFS_STATUS: prdata[lvr_pkg::ST_W-1:0] <= status;
                lvr_pkg::OFS_MASK:   prdata[lvr_pkg::ST_W-1:0] <= mask;
                default:             prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign pslverr = psel && penable && !mapped(paddr);

endmodule

/* lvr_ctrl_properties.sv */
// Port checks for the detector controller
`timescale 1ns/100ps
module lvr_ctrl_props #(
    parameter int FILT_CYC = 8
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        clk_en,
    // Option mode field
    input wire logic        det_mode_opt_hi,
    input wire logic        det_mode_opt_lo,
    // Comparators
    input wire logic        above_high_threshold,
    input wire logic        above_low_threshold,
    // Bus writes
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    // System side
    input wire logic        detector_reset,
    input wire logic        low_supply_irq,
    input wire logic        irq
);
    localparam int LAT = FILT_CYC + 3;
    wire  wr_en = psel && penable && pwrite && clk_en;
    logic we_sh;
    logic msk_sh;
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (reset);
    // Shadows follow bus writes; mask is forced by any reset
    always_ff @(posedge clk)
    begin
        if (reset)
            we_sh <= 1'b0;
        else if (wr_en && paddr == lvr_pkg::OFS_CTRL)
            we_sh <= pwdata[lvr_pkg::BIT_WE];
    end
    always_ff @(posedge clk)
    begin
        if (reset || detector_reset)
            msk_sh <= 1'b1;
        else if (wr_en && paddr == lvr_pkg::OFS_MASK)
            msk_sh <= pwdata[0];
    end
    sequence s_low_drop;
        // Only the two reset-capable mode codes must answer a low crossing
        $fell(above_low_threshold) && !we_sh && det_mode_opt_hi ##1 !above_low_threshold [*8];
    endsequence
    AST_RST_HOLD: assert property ($fell(reset) |-> detector_reset && !irq && !low_supply_irq)
        else $error("outputs wrong after reset");
    AST_RST_TIME: assert property ($fell(detector_reset) |-> $past(above_high_threshold, LAT))
        else $error("reset released too early");
    AST_LOW_RST: assert property (s_low_drop |-> ##[0:LAT] detector_reset)
        else $error("no reset below low level");
    AST_WARN_TIME: assert property (low_supply_irq |-> $past(above_high_threshold, LAT + 1)
        && !$past(above_high_threshold, LAT))
        else $error("warning not tied to a fall");
    AST_PULSE_ONE: assert property (low_supply_irq |=> !low_supply_irq)
        else $error("warning longer than one cycle");
    AST_IRQ_FOLLOW: assert property (low_supply_irq |-> ##[0:2] irq)
        else $error("warning without level request");
    AST_MASKED: assert property (msk_sh && $past(msk_sh) |-> !low_supply_irq)
        else $error("warning while masked");
    AST_WE_QUIET: assert property (we_sh && $past(we_sh) |-> !irq && !low_supply_irq
        && !$rose(detector_reset))
        else $error("event while write enable set");
endmodule
bind lvr_ctrl lvr_ctrl_props #(.FILT_CYC(FILT_CYC)) u_props (.clk(clk), .reset(reset),
    .clk_en(clk_en), .det_mode_opt_hi(det_mode_opt_hi), .det_mode_opt_lo(det_mode_opt_lo),
    .above_high_threshold(above_high_threshold), .psel(psel),
    .above_low_threshold(above_low_threshold), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .detector_reset(detector_reset),
    .low_supply_irq(low_supply_irq), .irq(irq));

/* lvr_supply_model.sv */
// Supply comparators and slow oscillator facing the controller
`timescale 1ns/100ps
module lvr_supply_model #(
    parameter int HIGH_MV = 2900,
    parameter int LOW_MV  = 2750
) (
    // Clock
    input  wire logic        clk,
    // Supply in millivolts
    input  wire logic [15:0] supply_mv,
    // Comparator and oscillator outputs
    output logic             above_high_threshold,
    output logic             above_low_threshold,
    output logic             slow_osc_clock
);
    logic [7:0] div_cnt = 8'h00;
    // Ideal, no hysteresis: all filtering must come from the design
    assign above_high_threshold = supply_mv >= 16'(HIGH_MV);
    assign above_low_threshold  = supply_mv >= 16'(LOW_MV);
    // Runs free through reset, like the real oscillator
    always_ff @(posedge clk)
        div_cnt <= div_cnt + 8'h01;
    assign slow_osc_clock = div_cnt[3];
endmodule

/* tb_top.sv */
// Self-checking bench for the detector controller
`timescale 1ns/100ps
`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module tb_top;
    localparam int LAT = 11;
    localparam logic [9:0] ROWS [3] = '{10'h381, 10'h101, 10'h200};
    logic        clk;
    logic        reset;
    logic        clk_en;
    logic        mode_hi;
    logic        mode_lo;
    logic [15:0] supply_mv;
    logic        above_hi;
    logic        above_lo;
    logic        osc;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        detector_reset;
    logic        low_supply_irq;
    logic        irq;
    logic [31:0] rd;
    logic        pslverr;
    logic        err;
    int          error_cnt;
    int          checks_done;
    int          pulses;
    int          n;
    lvr_supply_model u_sup (.clk(clk), .supply_mv(supply_mv), .above_high_threshold(above_hi),
        .above_low_threshold(above_lo), .slow_osc_clock(osc));
    lvr_ctrl #(.FILT_CYC(8), .SETTLE_MAX(20)) dut (.clk(clk), .reset(reset), .clk_en(clk_en),
        .det_mode_opt_hi(mode_hi), .det_mode_opt_lo(mode_lo), .above_high_threshold(above_hi),
        .above_low_threshold(above_lo), .slow_osc_clock(osc), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .detector_reset(detector_reset), .low_supply_irq(low_supply_irq),
        .irq(irq));
    always #25 clk = ~clk;
    always @(posedge clk)
        if (low_supply_irq === 1'b1)
            pulses++;
    task automatic results();
        $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic timeout();
        error_cnt++;
        $display("[ERR] t=%0t wait limit got=%h exp=%h", $time, 1'b0, 1'b1);
        results();
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 40);
        if (pready !== 1'b1)
            timeout();
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic step(input logic [15:0] v);
        @(posedge clk);
        supply_mv <= v;
    endtask
    // Counts negedges from a supply step; a change at edge LAT shows at negedge LAT + 1
    task automatic wait_out(input logic pulse, input logic v);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while ((pulse ? low_supply_irq : detector_reset) !== v && n < 200);
        if (n == 200)
            timeout();
    endtask
    initial
    begin
        {clk, psel, penable, pwrite, paddr, pwdata, supply_mv} = '0;
        {reset, clk_en, mode_hi, mode_lo} = 4'hE;
        {error_cnt, checks_done, pulses} = '0;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk);
            reset   <= 1'b1;
            mode_hi <= ROWS[i][9];
            mode_lo <= ROWS[i][8];
            repeat (3) @(posedge clk);
            reset <= 1'b0;
            rd_chk(lvr_pkg::OFS_LEVEL, {24'h0, ROWS[i][7:0]});
            rd_chk(lvr_pkg::OFS_CTRL, 32'h0);
            rd_chk(lvr_pkg::OFS_MASK, 32'h7);
            apb(1'b1, lvr_pkg::OFS_LEVEL, 32'h80);
            rd_chk(lvr_pkg::OFS_LEVEL, {24'h0, ROWS[i][7:0]});
            `CHK(detector_reset, 1'b1)
        end
        step(16'h0CE4);
        wait_out(1'b0, 1'b0);
        `CHK(n, LAT + 1)
        apb(1'b1, lvr_pkg::OFS_MASK, 32'h0);
        step(16'h0AF0);
        wait_out(1'b1, 1'b1);
        `CHK(n, LAT + 1)
        repeat (2) @(negedge clk);
        `CHK(irq, 1'b1)
        rd_chk(lvr_pkg::OFS_STATUS, 32'h1);
        step(16'h0CE4);
        repeat (3 * LAT) @(negedge clk);
        `CHK(pulses, 1)
        rd_chk(lvr_pkg::OFS_STATUS, 32'h0);
        step(16'h0AF0);
        wait_out(1'b1, 1'b1);
        step(16'h07D0);
        wait_out(1'b0, 1'b1);
        `CHK(n, LAT + 1)
        rd_chk(lvr_pkg::OFS_MASK, 32'h7);
        rd_chk(lvr_pkg::OFS_STATUS, 32'h3);
        step(16'h0CE4);
        wait_out(1'b0, 1'b0);
        // Mask is all set after the detector reset: a dip must stay silent
        step(16'h0AF0);
        repeat (3 * LAT) @(negedge clk);
        `CHK({pulses[1:0], irq}, 3'h4)
        step(16'h0CE4);
        repeat (3 * LAT) @(negedge clk);
        apb(1'b1, lvr_pkg::OFS_CTRL, 32'h80);
        n = 0;
        do
        begin
            apb(1'b0, lvr_pkg::OFS_STATUS, 32'h0);
            n++;
        end
        while (rd[2] !== 1'b1 && n < 40);
        `CHK(rd[2], 1'b1)
        apb(1'b1, lvr_pkg::OFS_LEVEL, 32'h81);
        rd_chk(lvr_pkg::OFS_LEVEL, 32'h81);
        apb(1'b1, lvr_pkg::OFS_LEVEL, 32'h0);
        rd_chk(lvr_pkg::OFS_LEVEL, 32'h0);
        apb(1'b1, lvr_pkg::OFS_MASK, 32'h0);
        step(16'h07D0);
        repeat (3 * LAT) @(negedge clk);
        `CHK({pulses[1:0], irq, detector_reset}, 4'h8)
        // Detector off: the external reset stands in, held for 10 us
        step(16'h0CE4);
        reset   <= 1'b1;
        mode_hi <= 1'b0;
        mode_lo <= 1'b0;
        repeat (10000 / lvr_pkg::CLK_PERIOD_NS) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(negedge clk);
        `CHK(detector_reset, 1'b0)
        rd_chk(8'h10, 32'h0);
        `CHK(err, 1'b1)
        @(posedge clk);
        clk_en <= 1'b0;
        @(negedge clk);
        `CHK(pready, 1'b0)
        results();
    end
endmodule
